// ### core/rotate_set_sleep_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - a=0 picks access bank; a=1 uses bank select register
// - a=0, extended set, f<=95: indexed literal offset address
// - rotate with d=1 writes result back to file register
// - rotate with d=0 writes accumulator, file untouched
// - opcode 0110 100a writes FFh to file, flags unchanged
// - word 0003h is sleep: clear power-down, set watchdog expiry
// - sleep clears watchdog count and postscaler
// - watchdog wake from sleep clears watchdog expiry flag
// - rotate right: bit n to n-1, old bit 0 to bit 7
module rotate_set_sleep_exec
  import rsse_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic            clkEn,
  input  wire logic [15:0]     instrWord,
  input  wire logic [7:0]      fileRdData,
  input  wire logic            wakeEvent,
  input  wire logic            wakeByWatchdog,
  input  wire logic [11:0]     indexBase,
  input  wire logic [3:0]      avsAddress,
  input  wire logic            avsRead,
  input  wire logic            avsWrite,
  input  wire logic [31:0]     avsWriteData,
  output logic      [31:0]     avsReadData,
  output logic                 avsWaitRequest,
  output rsse_pkg::filebus_t   fileBus,
  output logic      [7:0]      accum,
  output logic                 powerDownFlag,
  output logic                 watchdogExpiryFlag,
  output logic      [7:0]      watchdogCount,
  output logic      [3:0]      postscalerCount,
  output logic                 oscRun,
  output logic                 instrDone,
  output logic                 irq
);
  typedef struct packed {
    qphase_t     phase;
    decoded_t    dec;
    logic [7:0]  operand;
    logic [7:0]  result;
    filebus_t    bus;
    logic [7:0]  acc;
    logic        pd;
    logic        to;
    logic [7:0]  wdog;
    logic [3:0]  post;
    logic        sleeping;
    logic        done;
    logic        extEn;
    logic [3:0]  bank;
    logic [3:0]  irqStat;
    logic [3:0]  irqMask;
    logic [31:0] rdData;
    logic        ack;
    logic        irqOut;
  } state_t;

  state_t st_ff, nxt_st;
  logic   rstMeta_ff, rstSync_ff;
  logic [11:0] opAddr;
  logic        opIndexed;
  logic [3:0]  events;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  operand_addr u_addr (
    .accessBit   (instrWord[ACC_BIT]),
    .extendedEn  (st_ff.extEn),
    .bankSelect  (st_ff.bank),
    .fileOperand (instrWord[7:0]),
    .indexBase   (indexBase),
    .fileAddr    (opAddr),
    .indexed     (opIndexed)
  );

  always_comb begin
    nxt_st = st_ff;
    events = 4'h0;
    nxt_st.bus.wr = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.ack = 1'b0;
    // watchdog counts while awake; sleep clears it
    if (!st_ff.sleeping) begin
      {nxt_st.post, nxt_st.wdog} = {st_ff.post, st_ff.wdog} + 12'h001;
    end
    if (st_ff.sleeping) begin
      nxt_st.phase = Q1_DECODE;
      if (wakeEvent) begin
        nxt_st.sleeping = 1'b0;
        events[EV_WAKE] = 1'b1;
        if (wakeByWatchdog) begin
          nxt_st.to = 1'b0;
        end
      end
    end else begin
      case (st_ff.phase)
        Q1_DECODE: begin
          nxt_st.phase = Q2_READ;
          nxt_st.dec.addr = opAddr;
          nxt_st.dec.toFile = instrWord[DEST_BIT];
          if (instrWord == SLEEP_WORD) begin
            nxt_st.dec.kind = OP_SLEEP;
          end else if (instrWord[15:10] == ROTATE_OPCODE) begin
            nxt_st.dec.kind = OP_ROTATE;
          end else if (instrWord[15:9] == SETONES_OPCODE) begin
            nxt_st.dec.kind = OP_SETONES;
            nxt_st.dec.toFile = 1'b1;
          end else begin
            nxt_st.dec.kind = OP_NONE;
          end
        end
        Q2_READ: begin
          nxt_st.phase = Q3_PROCESS;
          nxt_st.operand = fileRdData;
        end
        Q3_PROCESS: begin
          nxt_st.phase = Q4_WRITE;
          if (st_ff.dec.kind == OP_ROTATE) begin
            nxt_st.result = rotr_nc(st_ff.operand);
          end else begin
            nxt_st.result = FILE_ONES;
          end
        end
        Q4_WRITE: begin
          nxt_st.phase = Q1_DECODE;
          nxt_st.done = 1'b1;
          nxt_st.bus.addr = st_ff.dec.addr;
          nxt_st.bus.data = st_ff.result;
          case (st_ff.dec.kind)
            OP_ROTATE: begin
              events[EV_ROTATE] = 1'b1;
              if (st_ff.dec.toFile) begin
                nxt_st.bus.wr = 1'b1;
              end else begin
                nxt_st.acc = st_ff.result;
              end
            end
            OP_SETONES: begin
              nxt_st.bus.wr = 1'b1;
              events[EV_SETONES] = 1'b1;
            end
            OP_SLEEP: begin
              events[EV_SLEEP] = 1'b1;
              nxt_st.pd = 1'b0;
              nxt_st.to = 1'b1;
              nxt_st.wdog = WDOG_CLEARED;
              nxt_st.post = POST_CLEARED;
              nxt_st.sleeping = 1'b1;
            end
            default: begin
            end
          endcase
        end
        default: nxt_st.phase = Q1_DECODE;
      endcase
    end
    // avalon slave: one wait cycle, then answer
    if ((avsRead || avsWrite) && !st_ff.ack) begin
      nxt_st.ack = 1'b1;
      nxt_st.rdData = 32'h0000_0000;
      if (avsRead) begin
        case (avsAddress)
          REG_CTRL:   nxt_st.rdData = {31'h0, st_ff.extEn};
          REG_BANK:   nxt_st.rdData = {28'h0, st_ff.bank};
          REG_STATUS: nxt_st.rdData = {26'h0, st_ff.sleeping, st_ff.pd,
                                       st_ff.to, st_ff.irqMask[2:0]};
          REG_IRQ_STAT: nxt_st.rdData = {28'h0, st_ff.irqStat};
          default: nxt_st.rdData = 32'h0000_0000;
        endcase
      end
    end
    // writes land only on the edge that sees waitrequest low
    if (avsWrite && st_ff.ack) begin
      case (avsAddress)
        REG_CTRL:   nxt_st.extEn = avsWriteData[0];
        REG_BANK:   nxt_st.bank = avsWriteData[3:0];
        REG_STATUS: nxt_st.irqMask = avsWriteData[3:0];
        default: begin
        end
      endcase
    end
    // read clears status; a new event in the same cycle wins
    if (avsRead && !st_ff.ack && avsAddress == REG_IRQ_STAT) begin
      nxt_st.irqStat = events;
    end else begin
      nxt_st.irqStat = st_ff.irqStat | events;
    end
    nxt_st.irqOut = |(nxt_st.irqStat & nxt_st.irqMask);
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      st_ff <= '{phase: Q1_DECODE, dec: '{kind: OP_NONE, toFile: 1'b0,
                 addr: 12'h000}, bus: '{addr: 12'h000, data: 8'h00,
                 wr: 1'b0}, pd: 1'b1, bank: BANK_RESET,
                 irqMask: MASK_RESET, default: '0};
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign avsReadData        = st_ff.rdData;
  assign avsWaitRequest     = !st_ff.ack;
  assign fileBus            = st_ff.bus;
  assign accum              = st_ff.acc;
  assign powerDownFlag      = st_ff.pd;
  assign watchdogExpiryFlag = st_ff.to;
  assign watchdogCount      = st_ff.wdog;
  assign postscalerCount    = st_ff.post;
  assign oscRun             = !st_ff.sleeping;
  assign instrDone          = st_ff.done;
  assign irq                = st_ff.irqOut;

  sleep_flags_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && !st_ff.sleeping && st_ff.phase == Q4_WRITE
      && st_ff.dec.kind == OP_SLEEP |=> st_ff.to && !st_ff.pd)
    else $error("sleep flags wrong");
  wdog_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    $rose(st_ff.sleeping) |-> st_ff.wdog == WDOG_CLEARED
      && st_ff.post == POST_CLEARED)
    else $error("watchdog not cleared");
  set_ones_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && st_ff.phase == Q4_WRITE && !st_ff.sleeping
      && st_ff.dec.kind == OP_SETONES |=> st_ff.bus.wr
      && st_ff.bus.data == FILE_ONES && $stable(st_ff.to))
    else $error("set ones wrong");
  rotate_val_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && st_ff.phase == Q3_PROCESS && st_ff.dec.kind == OP_ROTATE
      |=> st_ff.result == {$past(st_ff.operand[0]), $past(st_ff.operand[7:1])})
    else $error("rotate wrong");
  rotate_acc_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && st_ff.phase == Q4_WRITE && !st_ff.sleeping
      && st_ff.dec.kind == OP_ROTATE && !st_ff.dec.toFile
      |=> !st_ff.bus.wr && st_ff.acc == $past(st_ff.result))
    else $error("rotate to acc wrong");
  rotate_file_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && st_ff.phase == Q4_WRITE && !st_ff.sleeping
      && st_ff.dec.kind == OP_ROTATE && st_ff.dec.toFile |=> st_ff.bus.wr)
    else $error("rotate to file wrong");
  phase_order_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && !st_ff.sleeping && st_ff.phase == Q1_DECODE
      |=> st_ff.phase == Q2_READ)
    else $error("phase order wrong");
  osc_halt_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    st_ff.sleeping && !wakeEvent |=> !oscRun || !clkEn)
    else $error("oscillator not halted");
  wake_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && st_ff.sleeping && wakeEvent && wakeByWatchdog |=> !st_ff.to)
    else $error("wake did not clear flag");
  indexed_addr_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && !st_ff.sleeping && st_ff.phase == Q1_DECODE && opIndexed
    |=> st_ff.dec.addr == $past(indexBase) + {4'h0, $past(instrWord[7:0])})
    else $error("indexed address wrong");
  bank_addr_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && !st_ff.sleeping && st_ff.phase == Q1_DECODE
      && instrWord[ACC_BIT]
    |=> st_ff.dec.addr == {$past(st_ff.bank), $past(instrWord[7:0])})
    else $error("bank address wrong");
  // one wait cycle, never a hung bus
  wait_one_a: assert property (
    @(posedge clk_sys) disable iff (!rstSync_ff)
    clkEn && (avsRead || avsWrite) && !st_ff.ack |=> !avsWaitRequest)
    else $error("bus answer missing");
  sleep_c: cover property (@(posedge clk_sys) $rose(st_ff.sleeping));
  wake_c: cover property (@(posedge clk_sys) $fell(st_ff.sleeping));
  setw_c: cover property (@(posedge clk_sys) st_ff.bus.wr);
  irq_c: cover property (@(posedge clk_sys) st_ff.irqOut);
  indexed_c: cover property (@(posedge clk_sys) clkEn && opIndexed);
endmodule : rotate_set_sleep_exec
`default_nettype wire

// ### core/rsse_pkg.sv
package rsse_pkg;

  localparam logic [7:0] FILE_ONES       = 8'hFF;
  localparam logic [7:0] INDEXED_MAX     = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
  localparam logic [3:0] BANK_RESET      = 4'h0;
  localparam logic [5:0] ROTATE_OPCODE   = 6'h10;
  localparam logic [6:0] SETONES_OPCODE  = 7'h34;
  localparam logic [15:0] SLEEP_WORD     = 16'h0003;
  localparam logic [7:0] WDOG_CLEARED    = 8'h00;
  localparam logic [3:0] POST_CLEARED    = 4'h0;
  localparam logic [15:0] NOP_WORD       = 16'h0000;
  localparam int unsigned DEST_BIT       = 9;
  localparam int unsigned ACC_BIT        = 8;
  localparam int unsigned SETACC_BIT     = 8;

  // interrupt status bit positions
  localparam int unsigned EV_ROTATE      = 0;
  localparam int unsigned EV_SETONES     = 1;
  localparam int unsigned EV_SLEEP       = 2;
  localparam int unsigned EV_WAKE        = 3;
  localparam logic [3:0] MASK_RESET      = 4'h0;

  // register offsets (word aligned byte addresses)
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_BANK        = 4'h4;
  localparam logic [3:0] REG_STATUS      = 4'h8;
  localparam logic [3:0] REG_IRQ_STAT    = 4'hC;
  localparam logic [3:0] REG_IRQ_MASK    = 4'h0;

  typedef enum logic [1:0] {
    Q1_DECODE  = 2'h0,
    Q2_READ    = 2'h1,
    Q3_PROCESS = 2'h3,
    Q4_WRITE   = 2'h2
  } qphase_t;

  typedef enum logic [1:0] {
    OP_NONE    = 2'h0,
    OP_ROTATE  = 2'h1,
    OP_SETONES = 2'h2,
    OP_SLEEP   = 2'h3
  } opkind_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        wr;
  } filebus_t;

  typedef struct packed {
    opkind_t    kind;
    logic       toFile;
    logic [11:0] addr;
  } decoded_t;

  function automatic logic [7:0] rotr_nc(input logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction : rotr_nc

endpackage : rsse_pkg

// ### core/operand_addr.sv
`timescale 1ns/1ps
`default_nettype none
module operand_addr
  import rsse_pkg::*;
(
  input  wire logic        accessBit,
  input  wire logic        extendedEn,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [7:0]  fileOperand,
  input  wire logic [11:0] indexBase,
  output logic      [11:0] fileAddr,
  output logic             indexed
);
  always_comb begin
    indexed = !accessBit && extendedEn && (fileOperand <= INDEXED_MAX);
    if (indexed) begin
      fileAddr = indexBase + {4'h0, fileOperand};
    end else if (!accessBit) begin
      fileAddr = (fileOperand < ACCESS_SPLIT) ? {4'h0, fileOperand}
                                              : {ACCESS_HIGH_BANK, fileOperand};
    end else begin
      fileAddr = {bankSelect, fileOperand};
    end
  end
endmodule : operand_addr
`default_nettype wire

// ### verification/rotate_set_sleep_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_set_sleep_exec_bench;
  import rsse_pkg::*;
  logic        clk_sys, reset_n, clkEn, wakeEvent, wakeByWatchdog;
  logic [15:0] instrWord;
  logic [7:0]  fileRdData, accum, wrData, watchdogCount;
  logic [11:0] indexBase, wrAddr;
  logic [3:0]  avsAddress, postscalerCount;
  logic        avsRead, avsWrite, avsWaitRequest, powerDownFlag;
  logic        watchdogExpiryFlag, oscRun, instrDone, irq;
  logic [31:0] avsWriteData, avsReadData, rd;
  filebus_t    fileBus;
  int          badCount, testsRun, wrSeen;

  rotate_set_sleep_exec dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
    .instrWord(instrWord), .fileRdData(fileRdData),
    .wakeEvent(wakeEvent), .wakeByWatchdog(wakeByWatchdog),
    .indexBase(indexBase), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .fileBus(fileBus), .accum(accum), .powerDownFlag(powerDownFlag),
    .watchdogExpiryFlag(watchdogExpiryFlag),
    .watchdogCount(watchdogCount), .postscalerCount(postscalerCount),
    .oscRun(oscRun), .instrDone(instrDone), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= !wr;
    avsWriteData <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rd = avsReadData;
    chk("bus answer", 32'(n < 50), 32'h1);
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  // next decode shares the edge of a done pulse: drop the word at the
  // third one and let the fourth run drain, so no stray event follows
  task run(input logic [15:0] w, input logic [7:0] r);
    int n, k;
    n = 0;
    k = 0;
    wrSeen = 0;
    instrWord  <= w;
    fileRdData <= r;
    while (k < 4 && n < 60) begin
      @(posedge clk_sys);
      n++;
      if (instrDone === 1'b1) k++;
      if (k == 3) instrWord <= NOP_WORD;
      if (fileBus.wr === 1'b1) begin
        wrSeen++;
        wrAddr = fileBus.addr;
        wrData = fileBus.data;
      end
    end
    chk("completions", 32'(k), 32'h4);
  endtask : run

  task addr_case(input logic ext, input logic a, input logic [7:0] f,
                 input logic [11:0] exp);
    bus(1'b1, REG_CTRL, {31'h0, ext});
    run({SETONES_OPCODE, a, f}, 8'h5A);
    chk("file addr", 32'(wrAddr), 32'(exp));
    chk("ones data", 32'(wrData), 32'(FILE_ONES));
  endtask : addr_case

  task do_sleep(input logic byDog);
    int n;
    n = 0;
    instrWord <= SLEEP_WORD;
    do begin
      @(posedge clk_sys);
      n++;
    end while (oscRun !== 1'b0 && n < 40);
    instrWord <= NOP_WORD;
    chk("sleep entered", 32'(n < 40), 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("power down", 32'(powerDownFlag), 32'h0);
    chk("expiry set", 32'(watchdogExpiryFlag), 32'h1);
    chk("wdog count", 32'(watchdogCount), 32'(WDOG_CLEARED));
    chk("postscaler", 32'(postscalerCount), 32'(POST_CLEARED));
    repeat (8) @(posedge clk_sys);
    chk("still asleep", 32'(oscRun), 32'h0);
    wakeEvent      <= 1'b1;
    wakeByWatchdog <= byDog;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (oscRun !== 1'b1 && n < 40);
    wakeEvent      <= 1'b0;
    wakeByWatchdog <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("woken", 32'(n < 40), 32'h1);
    chk("expiry after wake", 32'(watchdogExpiryFlag), 32'(!byDog));
  endtask : do_sleep

  task test_regs;
    logic [7:0] held;
    chk("pd reset", 32'(powerDownFlag), 32'h1);
    chk("to reset", 32'(watchdogExpiryFlag), 32'h0);
    bus(1'b0, REG_BANK, 32'h0);
    chk("bank reset", rd, 32'(BANK_RESET));
    bus(1'b0, 4'h6, 32'h0);
    chk("unmapped read", rd, 32'h0);
    bus(1'b1, REG_BANK, 32'h5);
    bus(1'b0, REG_BANK, 32'h0);
    chk("bank readback", rd, 32'h5);
    clkEn <= 1'b0;
    @(posedge clk_sys);
    held = watchdogCount;
    repeat (9) @(posedge clk_sys);
    chk("frozen count", 32'(watchdogCount), 32'(held));
    clkEn <= 1'b1;
    $display("test regs done");
  endtask : test_regs

  task test_addr;
    addr_case(1'b0, 1'b1, 8'h23, 12'h523);
    addr_case(1'b0, 1'b0, 8'h5F, 12'h05F);
    addr_case(1'b0, 1'b0, 8'h60, 12'hF60);
    addr_case(1'b1, 1'b0, 8'h5F, 12'h35F);
    addr_case(1'b1, 1'b0, 8'h60, 12'hF60);
    addr_case(1'b1, 1'b0, 8'h00, 12'h300);
    addr_case(1'b1, 1'b1, 8'h10, 12'h510);
    $display("test addr done");
  endtask : test_addr

  task test_rotate;
    run({ROTATE_OPCODE, 1'b1, 1'b1, 8'h12}, 8'hD7);
    chk("rot file addr", 32'(wrAddr), 32'h512);
    chk("rot file data", 32'(wrData), 32'hEB);
    run({ROTATE_OPCODE, 1'b0, 1'b1, 8'h12}, 8'h01);
    chk("rot accum", 32'(accum), 32'h80);
    chk("rot no write", 32'(wrSeen), 32'h0);
    run({SETONES_OPCODE, 1'b1, 8'h40}, 8'h00);
    chk("ones accum kept", 32'(accum), 32'h80);
    chk("ones pd kept", 32'(powerDownFlag), 32'h1);
    chk("ones to kept", 32'(watchdogExpiryFlag), 32'h0);
    $display("test rotate done");
  endtask : test_rotate

  task test_irq;
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    bus(1'b1, REG_STATUS, 32'h0);
    run({ROTATE_OPCODE, 1'b0, 1'b1, 8'h01}, 8'h02);
    chk("irq masked", 32'(irq), 32'h0);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("rotate event", rd, 32'h1);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("read clears", rd, 32'h0);
    bus(1'b1, REG_STATUS, 32'hF);
    run({SETONES_OPCODE, 1'b1, 8'h02}, 8'h00);
    chk("irq raised", 32'(irq), 32'h1);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("setones event", rd, 32'h2);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test irq done");
  endtask : test_irq

  task test_sleep;
    do_sleep(1'b1);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("sleep events", rd, 32'hC);
    do_sleep(1'b0);
    $display("test sleep done");
  endtask : test_sleep

  task results;
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #100us;
    badCount++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    instrWord = NOP_WORD;
    fileRdData = 8'h00;
    wakeEvent = 1'b0;
    wakeByWatchdog = 1'b0;
    indexBase = 12'h300;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    badCount = 0;
    testsRun = 0;
    wrSeen = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    test_regs();
    test_addr();
    test_rotate();
    test_irq();
    test_sleep();
    results();
  end
endmodule : rotate_set_sleep_exec_bench
`default_nettype wire
